// file: design/serial_master_pkg.sv
// package: register map, field layout, reset values and types of the
// three-wire serial master transmit channel
// assumes a 32-bit AXI4-Lite register bus and one system clock
package serial_master_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_COMM_SETTING = 8'h00;
    localparam logic [7:0] OFF_DIVIDER = 8'h04;
    localparam logic [7:0] OFF_TX_DATA = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_START = 8'h10;
    localparam logic [7:0] OFF_STOP = 8'h14;
    localparam logic [7:0] OFF_OUT_ENABLE = 8'h18;
    localparam logic [7:0] OFF_OUT_LEVEL = 8'h1C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h20;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h24;

    // field positions
    localparam int POS_LEN8 = 0;
    localparam int POS_LSB_FIRST = 1;
    localparam int POS_DATA_PHASE = 2;
    localparam int POS_CLK_POL = 3;
    localparam int POS_CONT = 4;
    localparam int POS_PRESCALE = 0;
    localparam int POS_DIV_FIELD = 9;
    localparam int POS_ST_ENABLED = 0;
    localparam int POS_ST_BUF_FULL = 1;
    localparam int POS_ST_BUSY = 2;
    localparam int POS_ST_DATA_IN = 3;
    localparam int POS_IDLE_CLK = 8;

    // reset values and bus response codes
    localparam logic RST_OUT_ENABLE = 1'b0;
    localparam logic RST_OUT_LEVEL = 1'b1;
    localparam logic RST_IDLE_CLK = 1'b1;
    localparam logic [3:0] RST_PRESCALE = 4'h0;
    localparam logic [6:0] RST_DIV_FIELD = 7'h01;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // word lengths in half periods, last index
    localparam logic [3:0] LAST_HALF_8 = 4'hF;
    localparam logic [3:0] LAST_HALF_7 = 4'hD;

    typedef struct packed {
        logic cont;
        logic clk_pol;
        logic data_phase;
        logic lsb_first;
        logic len8;
    } comm_setting_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LEAD = 2'b01,
        ST_SHIFT = 2'b11
    } engine_e;

endpackage

// file: design/baud_divider.sv
// baud divider: prescaler by 2^sel then divide by (field+1), one tick
// per half transfer clock period
// assumes run is low between transfers so each half starts whole
`timescale 1ns/1ps
`default_nettype none
module baud_divider
    import serial_master_pkg::*;
#(
    parameter int PRESCALE_BITS = 4,
    parameter int DIV_BITS = 7
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // control
    input wire logic i_run,
    input wire logic [PRESCALE_BITS-1:0] i_prescale,
    input wire logic [DIV_BITS-1:0] i_div_field,
    // half period tick
    output logic o_tick
);
    localparam int PW = (1 << PRESCALE_BITS) - 1;

    initial begin
        if (PRESCALE_BITS < 1 || PRESCALE_BITS > 5 || DIV_BITS < 2 || DIV_BITS > 16) begin
            $error("baud_divider: unsupported widths");
        end
    end

    logic [PW-1:0] pre_cnt;
    logic [DIV_BITS-1:0] div_cnt;
    logic [DIV_BITS-1:0] div_end;
    logic pre_tick;

    // field below one is served as one: fastest clock is a quarter
    assign div_end = (i_div_field == '0) ? DIV_BITS'(1) : i_div_field;
    assign pre_tick = (pre_cnt == PW'((64'd1 << i_prescale) - 64'd1));
    assign o_tick = i_run && pre_tick && (div_cnt == div_end);

    // prescaler then per-channel counter
    always_ff @(posedge i_clk) begin
        if (i_srst || !i_run || pre_tick) begin
            pre_cnt <= '0;
        end else begin
            pre_cnt <= pre_cnt + PW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || !i_run || o_tick) begin
            div_cnt <= '0;
        end else if (pre_tick) begin
            div_cnt <= div_cnt + DIV_BITS'(1);
        end
    end
endmodule
`default_nettype wire

// file: design/three_wire_serial_master_tx.sv
// three-wire serial channel, master transmit path, AXI4-Lite registers
// assumes synchronous inputs, one 100 MHz clock, synchronous reset
//
// Summary of operation
// - channel uses clock out, data in and data out lines.
// - words are 7 or 8 bits, sent MSB or LSB first.
// - transfer clock comes from prescaler then per-channel counter.
// - fastest clock is system clock over four; slowest over 2*2^15*128.
// - master makes its own transfer clock and shifts data out.
// - interrupt marks transfer end in single, buffer empty in continuous.
// - phase 0 drives first bit with clock start; phase 1 half earlier.
// - phase 0: polarity 0 drives on falling edges, polarity 1 on rising edges; phase 1 swaps them.
// - stop trigger clears enabled status, halts, reads back as zero.
// - start trigger sets enabled status and allows communication.
// - with output disabled, data pin shows software output level.
// - writing data while buffer full overwrites the held word.
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module three_wire_serial_master_tx
    import serial_master_pkg::*;
#(
    parameter int PRESCALE_BITS = 4,
    parameter int DIV_BITS = 7
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // axi4-lite write
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // serial pins
    output logic o_transfer_clock_pin,
    output logic o_serial_data_out_pin,
    input wire logic i_serial_data_in_pin,
    // interrupt
    output logic o_channel_interrupt
);
    initial begin
        if (PRESCALE_BITS != 4 || DIV_BITS != 7) begin
            $error("three_wire_serial_master_tx: register layout needs 4/7 bits");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    comm_setting_s cfg;
    logic [PRESCALE_BITS-1:0] prescale;
    logic [DIV_BITS-1:0] div_field;
    logic [7:0] tx_buf;
    logic buffer_full_flag;
    logic operation_enabled_status;
    logic serial_output_enable;
    logic output_level_bit;
    logic idle_clock_level_bit;
    logic irq_status;
    logic irq_mask;
    logic data_in_seen;

    logic wr_go;
    logic wr_lo;
    logic start_wr;
    logic stop_wr;
    logic tx_wr;
    logic hit_w;
    logic hit_r;
    logic [31:0] next_rdata;

    engine_e st;
    logic [3:0] hc;
    logic [3:0] last_half;
    logic [7:0] sh;
    logic [7:0] aligned;
    logic [7:0] shifted;
    logic dout;
    logic pre;
    logic tick;
    logic run_ok;
    logic load_idle;
    logic load_end;
    logic load_early;
    logic load_now;
    logic word_end;
    logic evt;

    ////////////////////////////////////////////////////////////////////////
    // bus slave

    assign wr_go = i_awvalid && i_wvalid && !o_bvalid;
    assign o_awready = wr_go;
    assign o_wready = wr_go;
    assign o_arready = !o_rvalid;
    assign wr_lo = wr_go && i_wstrb[0];
    assign start_wr = wr_lo && i_awaddr == OFF_START && i_wdata[0];
    assign stop_wr = wr_lo && i_awaddr == OFF_STOP && i_wdata[0];
    assign tx_wr = wr_lo && i_awaddr == OFF_TX_DATA;

    always_comb begin
        hit_w = 1'b1;
        case (i_awaddr)
            OFF_COMM_SETTING, OFF_DIVIDER, OFF_TX_DATA, OFF_STATUS, OFF_START,
            OFF_STOP, OFF_OUT_ENABLE, OFF_OUT_LEVEL, OFF_IRQ_STATUS,
            OFF_IRQ_MASK: hit_w = 1'b1;
            default: hit_w = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp <= hit_w ? RESP_OKAY : RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // trigger registers read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        hit_r = 1'b1;
        case (i_araddr)
            OFF_COMM_SETTING: next_rdata[4:0] = cfg;
            OFF_DIVIDER: begin
                next_rdata[POS_PRESCALE +: PRESCALE_BITS] = prescale;
                next_rdata[POS_DIV_FIELD +: DIV_BITS] = div_field;
            end
            OFF_TX_DATA: next_rdata[7:0] = tx_buf;
            OFF_STATUS: begin
                next_rdata[POS_ST_ENABLED] = operation_enabled_status;
                next_rdata[POS_ST_BUF_FULL] = buffer_full_flag;
                next_rdata[POS_ST_BUSY] = st != ST_IDLE;
                next_rdata[POS_ST_DATA_IN] = data_in_seen;
            end
            OFF_START, OFF_STOP: next_rdata = 32'h0000_0000;
            OFF_OUT_ENABLE: next_rdata[0] = serial_output_enable;
            OFF_OUT_LEVEL: begin
                next_rdata[0] = output_level_bit;
                next_rdata[POS_IDLE_CLK] = idle_clock_level_bit;
            end
            OFF_IRQ_STATUS: next_rdata[0] = irq_status;
            OFF_IRQ_MASK: next_rdata[0] = irq_mask;
            default: hit_r = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= next_rdata;
            o_rresp <= hit_r ? RESP_OKAY : RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cfg <= '0;
            prescale <= RST_PRESCALE;
            div_field <= RST_DIV_FIELD;
        end else begin
            if (wr_lo && i_awaddr == OFF_COMM_SETTING) begin
                cfg <= i_wdata[4:0];
            end
            if (wr_go && i_awaddr == OFF_DIVIDER) begin
                if (i_wstrb[0]) begin
                    prescale <= i_wdata[POS_PRESCALE +: PRESCALE_BITS];
                end
                if (i_wstrb[1]) begin
                    div_field <= i_wdata[POS_DIV_FIELD +: DIV_BITS];
                end
            end
        end
    end

    // stop wins over start
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            operation_enabled_status <= 1'b0;
        end else if (stop_wr) begin
            operation_enabled_status <= 1'b0;
        end else if (start_wr) begin
            operation_enabled_status <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            serial_output_enable <= RST_OUT_ENABLE;
            output_level_bit <= RST_OUT_LEVEL;
            idle_clock_level_bit <= RST_IDLE_CLK;
        end else if (wr_go) begin
            if (i_wstrb[0] && i_awaddr == OFF_OUT_ENABLE) begin
                serial_output_enable <= i_wdata[0];
            end
            if (i_wstrb[0] && i_awaddr == OFF_OUT_LEVEL && !serial_output_enable) begin
                output_level_bit <= i_wdata[0];
            end
            // idle level is software's only while channel stopped
            if (i_wstrb[1] && i_awaddr == OFF_OUT_LEVEL && !operation_enabled_status) begin
                idle_clock_level_bit <= i_wdata[POS_IDLE_CLK];
            end
        end
    end

    // new word replaces held one; set wins over load
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tx_buf <= 8'h00;
            buffer_full_flag <= 1'b0;
        end else if (tx_wr) begin
            tx_buf <= i_wdata[7:0];
            buffer_full_flag <= 1'b1;
        end else if (load_now) begin
            buffer_full_flag <= 1'b0;
        end
    end

    // data in line level, observed for status
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            data_in_seen <= 1'b0;
        end else begin
            data_in_seen <= i_serial_data_in_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift engine

    baud_divider #(
        .PRESCALE_BITS(PRESCALE_BITS),
        .DIV_BITS(DIV_BITS)
    ) u_baud (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_run(st != ST_IDLE),
        .i_prescale(prescale),
        .i_div_field(div_field),
        .o_tick(tick)
    );

    // 7-bit msb-first word is left aligned
    assign last_half = cfg.len8 ? LAST_HALF_8 : LAST_HALF_7;
    assign aligned = (cfg.len8 || cfg.lsb_first) ? tx_buf : {tx_buf[6:0], 1'b0};
    assign shifted = cfg.lsb_first ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0};
    assign run_ok = operation_enabled_status && !stop_wr;
    assign load_idle = run_ok && st == ST_IDLE && buffer_full_flag;
    assign load_end = run_ok && st == ST_SHIFT && tick && hc == last_half && !pre
        && cfg.cont && buffer_full_flag;
    assign load_early = run_ok && st == ST_SHIFT && tick && cfg.data_phase
        && hc == last_half - 4'h1 && cfg.cont && buffer_full_flag;
    assign load_now = load_idle || load_end || load_early;
    assign word_end = run_ok && st == ST_SHIFT && tick && hc == last_half;
    // one interrupt source, chosen by mode
    assign evt = cfg.cont ? load_now : word_end;

    always_ff @(posedge i_clk) begin
        if (i_srst || !run_ok) begin
            st <= ST_IDLE;
            hc <= 4'h0;
            pre <= 1'b0;
        end else begin
            case (st)
                ST_IDLE: begin
                    if (load_idle) begin
                        st <= cfg.data_phase ? ST_LEAD : ST_SHIFT;
                        hc <= 4'h0;
                    end
                end
                ST_LEAD: begin
                    if (tick) begin
                        st <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (tick && hc == last_half) begin
                        hc <= 4'h0;
                        pre <= 1'b0;
                        if (!pre && !load_end) begin
                            st <= ST_IDLE;
                        end
                    end else if (tick) begin
                        hc <= hc + 4'h1;
                        if (load_early) begin
                            pre <= 1'b1;
                        end
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // data changes at start of active half, or half earlier
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            sh <= 8'h00;
            dout <= 1'b0;
        end else if (load_now) begin
            sh <= aligned;
            dout <= cfg.lsb_first ? aligned[0] : aligned[7];
        end else if (st == ST_SHIFT && tick && hc != last_half
                && (cfg.data_phase ? !hc[0] : hc[0])) begin
            sh <= shifted;
            dout <= cfg.lsb_first ? shifted[0] : shifted[7];
        end
    end

    // active half at polarity level, idle at software level
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_transfer_clock_pin <= RST_IDLE_CLK;
        end else if (load_idle && !cfg.data_phase) begin
            o_transfer_clock_pin <= cfg.clk_pol;
        end else if (run_ok && st == ST_LEAD && tick) begin
            o_transfer_clock_pin <= cfg.clk_pol;
        end else if (run_ok && st == ST_SHIFT && tick
                && (hc != last_half || pre || load_end)) begin
            o_transfer_clock_pin <= hc[0] ? cfg.clk_pol : !cfg.clk_pol;
        end else if (st == ST_IDLE || !run_ok || (st == ST_SHIFT && tick)) begin
            o_transfer_clock_pin <= idle_clock_level_bit;
        end
    end

    // software level replaces engine when output disabled
    assign o_serial_data_out_pin = serial_output_enable ? dout : output_level_bit;

    ////////////////////////////////////////////////////////////////////////
    // interrupt, set wins over write-one clear

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            irq_status <= 1'b0;
            irq_mask <= 1'b0;
        end else begin
            if (evt) begin
                irq_status <= 1'b1;
            end else if (wr_lo && i_awaddr == OFF_IRQ_STATUS && i_wdata[0]) begin
                irq_status <= 1'b0;
            end
            if (wr_lo && i_awaddr == OFF_IRQ_MASK) begin
                irq_mask <= i_wdata[0];
            end
        end
    end

    assign o_channel_interrupt = irq_status && irq_mask;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_stop_write;
        stop_wr;
    endsequence

    sequence s_halted;
        !operation_enabled_status && st == ST_IDLE;
    endsequence

    a_stop_halts: assert property (s_stop_write |=> s_halted)
        else $error("stop trigger did not halt channel");
    a_start_enables: assert property (start_wr && !stop_wr |=> operation_enabled_status)
        else $error("start trigger did not enable channel");
    a_out_level_mux: assert property (!serial_output_enable |-> o_serial_data_out_pin == output_level_bit)
        else $error("data pin not showing software level");
    a_tx_overwrite: assert property (tx_wr |=> buffer_full_flag && tx_buf == $past(i_wdata[7:0]))
        else $error("transmit data not overwritten");
    a_half_min_two: assert property (tick |=> !tick)
        else $error("half period shorter than two clocks");
    a_irq_mode_sel: assert property ($rose(irq_status)
        |-> ($past(cfg.cont) ? $past(load_now) : $past(word_end)))
        else $error("interrupt from wrong source");
    a_phase0_start: assert property (load_idle && !cfg.data_phase
        |=> st == ST_SHIFT && o_transfer_clock_pin == $past(cfg.clk_pol))
        else $error("phase 0 first bit not with clock start");
    a_lead_idle_clk: assert property (st == ST_LEAD && !tick |=> o_transfer_clock_pin == idle_clock_level_bit)
        else $error("clock moved during lead half");
    a_cont_no_gap: assert property (load_end |=> st == ST_SHIFT && hc == 4'h0)
        else $error("continuous word left a gap");
    a_idle_clock: assert property (st == ST_IDLE && $past(st) == ST_IDLE && !$past(load_idle)
        |-> o_transfer_clock_pin == $past(idle_clock_level_bit))
        else $error("idle clock level wrong");
endmodule
`default_nettype wire

// file: tb/serial_slave_model.sv
// model: external slave receiving the transfer clock and serial data
// assumes i_pol names the sampling edge: 0 rising, 1 falling
`timescale 1ns/1ps
`default_nettype none
module serial_slave_model (
    // serial lines
    input wire logic i_clk_pin,
    input wire logic i_data_pin,
    output logic o_reply,
    // control and capture
    input wire logic i_pol,
    input wire logic i_clr,
    output logic [15:0] o_bits,
    output logic [4:0] o_count,
    output var time o_span
);
    time t0;
    ////////////////////////////////////////
    // sample on rising edge for i_pol 0, falling edge for 1
    always @(i_clk_pin or posedge i_clr) begin
        if (i_clr) begin
            o_bits = 16'h0;
            o_count = 5'h0;
        end else if (i_clk_pin === ~i_pol) begin
            if (o_count == 5'h0) begin
                t0 = $time;
            end
            o_span = $time - t0;
            o_bits = {o_bits[14:0], i_data_pin};
            o_count = o_count + 5'h1;
        end
    end
    // reply is the inverse of the last sampled bit; model never clocks the device
    assign o_reply = ~o_bits[0];
endmodule
`default_nettype wire

// file: tb/three_wire_serial_master_tx_tb.sv
// testbench: register accesses over the bus, words checked by a slave model
// assumes the design answers each bus request within a few hundred cycles
`timescale 1ns/1ps
`default_nettype none
module three_wire_serial_master_tx_tb;
    import serial_master_pkg::*;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic clk = 1'h0, srst = 1'h1, clr = 1'h0, pol = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, d;
    logic [31:0] wdata = 32'h0, rdata, rd_data;
    logic awready, wready, bvalid, arready, rvalid, sck, sdo, sdi, irq;
    logic [1:0] bresp, rresp, resp;
    logic [15:0] bits;
    logic [4:0] cnt;
    time span;
    int fails = 0, num_checks = 0;
    always #5 clk = ~clk;
    three_wire_serial_master_tx three_wire_serial_master_tx_i (
        .i_clk(clk), .i_srst(srst),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .o_transfer_clock_pin(sck), .o_serial_data_out_pin(sdo),
        .i_serial_data_in_pin(sdi), .o_channel_interrupt(irq)
    );
    serial_slave_model serial_slave_model_i (
        .i_clk_pin(sck), .i_data_pin(sdo), .o_reply(sdi), .i_pol(pol),
        .i_clr(clr), .o_bits(bits), .o_count(cnt), .o_span(span)
    );
    ////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 500; n++) begin
            @(posedge clk);
            if (s === 1'h1) return;
        end
        fails++;
        close_out();
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        wait_hi(awready);
        awvalid <= 1'h0;
        wvalid <= 1'h0;
        wait_hi(bvalid);
        resp = bresp;
        bready <= 1'h0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        wait_hi(arready);
        arvalid <= 1'h0;
        wait_hi(rvalid);
        rd_data = rdata;
        resp = rresp;
        rready <= 1'h0;
        chk(rd_data & m, e);
    endtask
    task automatic setup(input logic [4:0] cfg);
        w(OFF_STOP, 32'h1);
        w(OFF_COMM_SETTING, {27'h0, cfg});
        w(OFF_OUT_LEVEL, {23'h0, ~cfg[3], 8'h01});
        pol <= cfg[3] ^ cfg[2]; // sampling edge swaps with data phase
        @(posedge clk);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        w(OFF_START, 32'h1);
    endtask
    function automatic logic [15:0] exp_bits(input logic [7:0] v, input logic l8, input logic lsb);
        logic [15:0] e;
        e = 16'h0;
        for (int k = 0; k < (l8 ? 8 : 7); k++) begin
            e = {e[14:0], lsb ? v[k] : v[(l8 ? 7 : 6) - k]};
        end
        return e;
    endfunction
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        rchk(OFF_COMM_SETTING, ALL, 32'h0);
        rchk(OFF_DIVIDER, ALL, 32'h200);
        rchk(OFF_OUT_ENABLE, ALL, 32'h0);
        rchk(OFF_OUT_LEVEL, ALL, 32'h101);
        rchk(OFF_IRQ_MASK, ALL, 32'h0);
        rchk(OFF_STATUS, 32'h7, 32'h0);
        chk(sck, 32'h1);
        chk(sdo, 32'h1);
        w(8'h40, 32'h1);
        chk(32'(resp), 32'(RESP_SLVERR));
        rchk(8'h40, ALL, 32'h0);
        chk(32'(resp), 32'(RESP_SLVERR));
        w(OFF_OUT_LEVEL, 32'h100);
        chk(sdo, 32'h0);
        w(OFF_OUT_ENABLE, 32'h1);
        w(OFF_IRQ_MASK, 32'h1);
        for (int i = 0; i < 16; i++) begin
            setup(i[4:0]);
            rchk(OFF_STATUS, 32'h1, 32'h1);
            rchk(OFF_START, ALL, 32'h0);
            d = 8'h5A ^ 8'(i * 8'h25);
            w(OFF_TX_DATA, {24'h0, d});
            wait_hi(irq);
            chk(32'(bits), 32'(exp_bits(d, i[0], i[1])));
            chk(32'(cnt), i[0] ? 32'h8 : 32'h7);
            chk(32'(span), i[0] ? 32'h118 : 32'hF0);
            chk(sck, i[3] ? 32'h0 : 32'h1);
            w(OFF_IRQ_STATUS, 32'h1);
            chk(irq, 32'h0);
        end
        for (int j = 0; j < 2; j++) begin
            setup(j ? 5'h15 : 5'h11);
            w(OFF_TX_DATA, 32'hC3);
            w(OFF_TX_DATA, 32'h3C);
            w(OFF_TX_DATA, 32'h96);
            w(OFF_IRQ_STATUS, 32'h1);
            wait_hi(irq);
            for (int n = 0; n < 200 && cnt != 5'h10; n++) begin
                @(posedge clk);
            end
            chk(32'(bits), 32'hC396);
            chk(32'(span), 32'h258);
        end
        rchk(OFF_STATUS, 32'h8, 32'h8);
        w(OFF_IRQ_MASK, 32'h0);
        chk(irq, 32'h0);
        rchk(OFF_IRQ_STATUS, 32'h1, 32'h1);
        w(OFF_IRQ_STATUS, 32'h1);
        rchk(OFF_IRQ_STATUS, 32'h1, 32'h0);
        setup(5'h01);
        w(OFF_TX_DATA, 32'hFF);
        w(OFF_STOP, 32'h1);
        rchk(OFF_STATUS, 32'h5, 32'h0);
        rchk(OFF_STOP, ALL, 32'h0);
        chk(sck, 32'h1);
        close_out();
    end
endmodule
`default_nettype wire
